// *** design/sgr_regfile.sv ***
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
// Function
// R1: Mask bit n+16 high lets bit n update.
// R2: Mask bit low keeps the bit unchanged.
// R3: Pull registers hold two 8-bit pin groups.
// R4: Pull bit zero enables pad pull.
// R5: Headset debounce 5/15/35/50 ms, reset code 10.
// R6: Codec bit 3 enables headset falling interrupt.
// R7: Codec bit 2 enables headset rising interrupt.
// R8: Headset pending bits cleared by writing one.
// R9: Card debounce uses same encoding, reset 10.
// R10: Control 0 bits 3/2 enable card edges.
// R11: Card pending bits cleared by writing one.
// R12: Edges set pending; enabled pending drives interrupt.
// R13: Remap puts boot ROM at high address.
// R14: Bit 8 forces debug pinmux, resets one.
// R15: Bit 10 picks audio input source.
// R16: Software sets narrow bit for 16-bit memory.
// R17: Bits 6/7 control memory monitor and type.
// R18: Control 1 drives PHY lane test enables.
// R19: Bits 4:3 select serial-port pin set.
// R20: Control 2 bits 15:8 request domain idle.
// R21: Bit 2 keeps memory PHY normal, resets one.
// R22: Software sets bit 7 for gen3 memory.
// R23: Reserved bits read zero, ignore writes.
module sgr_regfile #(
  parameter int DEB_CNT0 = sgr_pkg::DEB_C0,
  parameter int DEB_CNT1 = sgr_pkg::DEB_C1,
  parameter int DEB_CNT2 = sgr_pkg::DEB_C2,
  parameter int DEB_CNT3 = sgr_pkg::DEB_C3
) (
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Register port.
  input  wire logic [11:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Detect pins, asynchronous.
  input  wire logic        i_headset_detect,
  input  wire logic        i_card_detect,
  // Interrupts.
  output logic             o_headset_irq,
  output logic             o_card_irq,
  // Pad pull disables.
  output logic      [7:0]  o_port3_group_a_pull_dis,
  output logic      [7:0]  o_port3_group_b_pull_dis,
  output logic      [7:0]  o_port3_group_c_pull_dis,
  output logic      [7:0]  o_port3_group_d_pull_dis,
  // SoC control 0 outputs.
  output logic             o_remap,
  output logic      [31:0] o_boot_rom_base,
  output logic             o_force_debug_mux,
  output logic             o_audio_src_codec,
  output logic             o_codec_loopback,
  output logic             o_narrow_memory_enable,
  output logic             o_memory_width_sched,
  output logic             o_monitor_start,
  output logic             o_monitor_lowpower_type,
  output logic             o_hdmi_clk_sel,
  // SoC control 1 outputs.
  output logic      [3:0]  o_phy_lane_test_mode,
  output logic             o_phy_clk_test_mode,
  output logic      [1:0]  o_spi_pin_select,
  output logic             o_i2s_pin_select,
  output logic             o_emmc_pin_select,
  output logic             o_vpu_clk_sel,
  output logic             o_codec_sel,
  // SoC control 2 outputs.
  output logic      [7:0]  o_domain_idle_req,
  output logic             o_gen3_memory_select,
  output logic             o_usb_host_sel,
  output logic             o_phy_normal,
  output logic             o_self_refresh_req
);
  function automatic logic [15:0] masked(input logic [15:0] old_v, input logic [31:0] wd,
                                         input logic [15:0] keep);
    masked = (old_v & ~(wd[31:16] & keep)) | (wd[15:0] & wd[31:16] & keep);
  endfunction : masked

  function automatic logic [31:0] deb_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: deb_limit = 32'(DEB_CNT0);
      2'h1: deb_limit = 32'(DEB_CNT1);
      2'h2: deb_limit = 32'(DEB_CNT2);
      2'h3: deb_limit = 32'(DEB_CNT3);
    endcase
  endfunction : deb_limit

  logic [15:0] pull_low;
  logic [15:0] pull_high;
  logic [15:0] codec_det;
  logic [15:0] soc0;
  logic [15:0] soc1;
  logic [15:0] soc2;
  logic [1:0]  hs_sync;
  logic [1:0]  cd_sync;
  logic [1:0]  deb_state;
  logic [31:0] hs_cnt;
  logic [31:0] cd_cnt;

  wire         wr_pl   = i_wr && (i_addr == sgr_pkg::OFF_PULL_P3_LOW);
  wire         wr_ph   = i_wr && (i_addr == sgr_pkg::OFF_PULL_P3_HIGH);
  wire         wr_cd   = i_wr && (i_addr == sgr_pkg::OFF_CODEC_DET);
  wire         wr_s0   = i_wr && (i_addr == sgr_pkg::OFF_SOC_CTRL0);
  wire         wr_s1   = i_wr && (i_addr == sgr_pkg::OFF_SOC_CTRL1);
  wire         wr_s2   = i_wr && (i_addr == sgr_pkg::OFF_SOC_CTRL2);
  // Debounced levels change only after the input held for the selected time.
  wire         hs_chg  = (hs_sync[1] != deb_state[0]);
  wire         cd_chg  = (cd_sync[1] != deb_state[1]);
  wire [31:0]  hs_lim  = deb_limit(codec_det[sgr_pkg::POS_DEB_LO +: 2]);
  wire [31:0]  cd_lim  = deb_limit(soc0[sgr_pkg::POS_DEB_LO +: 2]);
  wire         hs_flip = hs_chg && (hs_cnt >= hs_lim - 32'h1);
  wire         cd_flip = cd_chg && (cd_cnt >= cd_lim - 32'h1);
  // R12 edge pending set
  wire [1:0]   hs_set  = {hs_flip && !hs_sync[1], hs_flip && hs_sync[1]};
  wire [1:0]   cd_set  = {cd_flip && !cd_sync[1], cd_flip && cd_sync[1]};
  // R8 write one clears
  wire [1:0]   hs_clr  = (wr_cd ? i_wdata[1:0] & i_wdata[17:16] : 2'h0);
  // R11 write one clears
  wire [1:0]   cd_clr  = (wr_s0 ? i_wdata[1:0] & i_wdata[17:16] : 2'h0);
  // Set wins over clear so an edge in the clearing cycle is kept.
  wire [1:0]   hs_pend = (codec_det[1:0] & ~hs_clr) | hs_set;
  wire [1:0]   cd_pend = (soc0[1:0] & ~cd_clr) | cd_set;
  // R1 masked update
  // R2 unmasked bits hold
  // R23 reserved masked out
  wire [15:0]  next_pl = wr_pl ? masked(pull_low, i_wdata, sgr_pkg::MASK_PULL) : pull_low;
  wire [15:0]  next_ph = wr_ph ? masked(pull_high, i_wdata, sgr_pkg::MASK_PULL) : pull_high;
  wire [15:0]  cd_base = wr_cd ? masked(codec_det, i_wdata, 16'h003c) : codec_det;
  wire [15:0]  s0_base = wr_s0 ? masked(soc0, i_wdata, sgr_pkg::MASK_SOC_CTRL0 & 16'hfffc)
                               : soc0;
  wire [15:0]  next_cd = {cd_base[15:2], hs_pend};
  wire [15:0]  next_s0 = {s0_base[15:2], cd_pend};
  wire [15:0]  next_s1 = wr_s1 ? masked(soc1, i_wdata, sgr_pkg::MASK_SOC_CTRL1) : soc1;
  wire [15:0]  next_s2 = wr_s2 ? masked(soc2, i_wdata, sgr_pkg::MASK_SOC_CTRL2) : soc2;

  wire [15:0]  rd_sel  = (i_addr == sgr_pkg::OFF_PULL_P3_LOW)  ? pull_low  :
                         (i_addr == sgr_pkg::OFF_PULL_P3_HIGH) ? pull_high :
                         (i_addr == sgr_pkg::OFF_CODEC_DET)    ? codec_det :
                         (i_addr == sgr_pkg::OFF_SOC_CTRL0)    ? soc0      :
                         (i_addr == sgr_pkg::OFF_SOC_CTRL1)    ? soc1      :
                         (i_addr == sgr_pkg::OFF_SOC_CTRL2)    ? soc2      : 16'h0000;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      pull_low  <= sgr_pkg::RST_PULL;
      pull_high <= sgr_pkg::RST_PULL;
      // R5 headset reset code
      codec_det <= sgr_pkg::RST_CODEC_DET;
      // R9 card reset code
      soc0      <= sgr_pkg::RST_SOC_CTRL0;
      soc1      <= sgr_pkg::RST_SOC_CTRL1;
      soc2      <= sgr_pkg::RST_SOC_CTRL2;
      o_rdata   <= 32'h0;
    end else begin
      pull_low  <= next_pl;
      pull_high <= next_ph;
      codec_det <= next_cd;
      soc0      <= next_s0;
      soc1      <= next_s1;
      soc2      <= next_s2;
      // Write-mask half reads as zero; it is never stored.
      o_rdata   <= i_rd ? {16'h0000, rd_sel} : 32'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      hs_sync   <= 2'h0;
      cd_sync   <= 2'h0;
      deb_state <= 2'h0;
      hs_cnt    <= 32'h0;
      cd_cnt    <= 32'h0;
    end else begin
      hs_sync   <= {hs_sync[0], i_headset_detect};
      cd_sync   <= {cd_sync[0], i_card_detect};
      // R5 headset debounce time
      hs_cnt    <= (hs_chg && !hs_flip) ? hs_cnt + 32'h1 : 32'h0;
      // R9 card debounce time
      cd_cnt    <= (cd_chg && !cd_flip) ? cd_cnt + 32'h1 : 32'h0;
      deb_state <= {cd_flip ? cd_sync[1] : deb_state[1], hs_flip ? hs_sync[1] : deb_state[0]};
    end
  end

  // R3 two groups per register
  // R4 zero means pull enabled
  assign o_port3_group_a_pull_dis = pull_low[7:0];
  assign o_port3_group_b_pull_dis = pull_low[15:8];
  assign o_port3_group_c_pull_dis = pull_high[7:0];
  assign o_port3_group_d_pull_dis = pull_high[15:8];
  // R6 headset fall enable
  // R7 headset rise enable
  // R12 enabled pending interrupt
  assign o_headset_irq = |(codec_det[1:0] & codec_det[3:2]);
  // R10 card edge enables
  assign o_card_irq    = |(soc0[1:0] & soc0[3:2]);
  // R13 boot remap
  assign o_remap                 = soc0[sgr_pkg::POS_REMAP];
  assign o_boot_rom_base         = soc0[sgr_pkg::POS_REMAP] ? sgr_pkg::BOOT_ROM_REMAP : 32'h0;
  // R14 force debug mux
  assign o_force_debug_mux       = soc0[sgr_pkg::POS_FORCE_DEBUG];
  // R15 audio source select
  assign o_audio_src_codec       = soc0[sgr_pkg::POS_AUDIO_SRC];
  assign o_codec_loopback        = soc0[sgr_pkg::POS_LOOPBACK];
  // R16 narrow memory bits
  assign o_narrow_memory_enable  = soc0[sgr_pkg::POS_NARROW_MEM];
  assign o_memory_width_sched    = soc0[sgr_pkg::POS_WIDTH_SCHED];
  // R17 monitor controls
  assign o_monitor_start         = soc0[sgr_pkg::POS_MON_START];
  assign o_monitor_lowpower_type = soc0[sgr_pkg::POS_MON_LOWPWR];
  assign o_hdmi_clk_sel          = soc0[sgr_pkg::POS_HDMI_CLK];
  // R18 PHY test lanes
  assign o_phy_lane_test_mode    = soc1[sgr_pkg::POS_PHY_LANE_LO +: 4];
  assign o_phy_clk_test_mode     = soc1[sgr_pkg::POS_PHY_CLK_TEST];
  // R19 serial pin set
  assign o_spi_pin_select        = soc1[sgr_pkg::POS_SPI_MUX_LO +: 2];
  assign o_i2s_pin_select        = soc1[sgr_pkg::POS_I2S_MUX];
  assign o_emmc_pin_select       = soc1[sgr_pkg::POS_EMMC_MUX];
  assign o_vpu_clk_sel           = soc1[sgr_pkg::POS_VPU_CLK];
  assign o_codec_sel             = soc1[sgr_pkg::POS_CODEC_SEL];
  // R20 domain idle requests
  assign o_domain_idle_req       = soc2[sgr_pkg::POS_IDLE_LO +: 8];
  // R22 gen3 memory bit
  assign o_gen3_memory_select    = soc2[sgr_pkg::POS_GEN3_MEM];
  assign o_usb_host_sel          = soc2[sgr_pkg::POS_HOST_SEL];
  // R21 PHY normal bit
  assign o_phy_normal            = soc2[sgr_pkg::POS_PHY_NORMAL];
  assign o_self_refresh_req      = soc2[sgr_pkg::POS_SELF_REFRESH];

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  mask_hold_a: assert property (wr_s1 && i_wdata[27] == 1'b0 |=> soc1[11] == $past(soc1[11])) // R2
    else $error("masked-off bit changed");
  mask_write_a: assert property (wr_s1 && i_wdata[27] |=> soc1[11] == $past(i_wdata[11])) // R1
    else $error("masked bit not written");
  reserved_zero_a: assert property (i_rd |=> o_rdata[31:16] == 16'h0 && (
    $past(i_addr) != sgr_pkg::OFF_SOC_CTRL1 || o_rdata[2:0] == 3'h0)) // R23
    else $error("reserved bits not zero");
  hs_clear_a: assert property (wr_cd && i_wdata[16] && i_wdata[0] && !hs_set[0]
    |=> !codec_det[0]) // R8
    else $error("headset pending not cleared");
  card_clear_a: assert property (wr_s0 && i_wdata[17] && i_wdata[1] && !cd_set[1]
    |=> !soc0[1]) // R11
    else $error("card pending not cleared");
  hs_set_a: assert property (hs_set[1] |=> codec_det[1]) // R12
    else $error("headset fall pending lost");
  card_irq_a: assert property (soc0[0] && soc0[2] |-> o_card_irq) // R10
    else $error("card rise interrupt missing");
  hs_irq_a: assert property (codec_det[1] && !codec_det[3] && !(codec_det[0] && codec_det[2])
    |-> !o_headset_irq) // R6
    else $error("headset fall interrupt not gated");
  deb_time_a: assert property (hs_flip |-> hs_cnt == hs_lim - 32'h1) // R5
    else $error("headset debounce time wrong");
  remap_a: assert property (o_remap |-> o_boot_rom_base == sgr_pkg::BOOT_ROM_REMAP) // R13
    else $error("remap base wrong");

  hs_rise_c: cover property (hs_set[0]);
  card_fall_c: cover property (cd_set[1]);
  irq_c: cover property (o_headset_irq ##1 !o_headset_irq);
  set_clear_c: cover property (hs_set[0] && hs_clr[0]);
endmodule : sgr_regfile

// *** include/sgr_pkg.sv ***
package sgr_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFF_PULL_P3_LOW  = 12'h130;
  localparam logic [11:0] OFF_PULL_P3_HIGH = 12'h134;
  localparam logic [11:0] OFF_CODEC_DET    = 12'h13c;
  localparam logic [11:0] OFF_SOC_CTRL0    = 12'h140;
  localparam logic [11:0] OFF_SOC_CTRL1    = 12'h144;
  localparam logic [11:0] OFF_SOC_CTRL2    = 12'h148;
  // Writable bit masks; other low bits are reserved and read zero.
  localparam logic [15:0] MASK_PULL        = 16'hffff;
  localparam logic [15:0] MASK_CODEC_DET   = 16'h003f;
  localparam logic [15:0] MASK_SOC_CTRL0   = 16'hfdff;
  localparam logic [15:0] MASK_SOC_CTRL1   = 16'hfcf8;
  localparam logic [15:0] MASK_SOC_CTRL2   = 16'hff8f;
  // Reset values.
  localparam logic [15:0] RST_PULL         = 16'h0000;
  localparam logic [15:0] RST_CODEC_DET    = 16'h0020;
  localparam logic [15:0] RST_SOC_CTRL0    = 16'h0120;
  localparam logic [15:0] RST_SOC_CTRL1    = 16'h0000;
  localparam logic [15:0] RST_SOC_CTRL2    = 16'h0084;
  // Detect field positions, shared by both detect registers.
  localparam int          POS_DEB_LO       = 4;
  localparam int          POS_FALL_EN      = 3;
  localparam int          POS_RISE_EN      = 2;
  localparam int          POS_FALL_PEND    = 1;
  localparam int          POS_RISE_PEND    = 0;
  // SoC control 0 fields.
  localparam int          POS_MON_START    = 6;
  localparam int          POS_MON_LOWPWR   = 7;
  localparam int          POS_FORCE_DEBUG  = 8;
  localparam int          POS_AUDIO_SRC    = 10;
  localparam int          POS_LOOPBACK     = 11;
  localparam int          POS_REMAP        = 12;
  localparam int          POS_WIDTH_SCHED  = 13;
  localparam int          POS_NARROW_MEM   = 14;
  localparam int          POS_HDMI_CLK     = 15;
  // SoC control 1 fields.
  localparam int          POS_SPI_MUX_LO   = 3;
  localparam int          POS_I2S_MUX      = 5;
  localparam int          POS_EMMC_MUX     = 6;
  localparam int          POS_PHY_CLK_TEST = 7;
  localparam int          POS_VPU_CLK      = 10;
  localparam int          POS_PHY_LANE_LO  = 11;
  localparam int          POS_CODEC_SEL    = 15;
  // SoC control 2 fields.
  localparam int          POS_SELF_REFRESH = 1;
  localparam int          POS_PHY_NORMAL   = 2;
  localparam int          POS_HOST_SEL     = 3;
  localparam int          POS_GEN3_MEM     = 7;
  localparam int          POS_IDLE_LO      = 8;
  // Boot remap target.
  localparam logic [31:0] BOOT_ROM_REMAP   = 32'h10100000;
  // Debounce times in microseconds and clock rate in kHz.
  localparam int          CLK_KHZ          = 20000;
  localparam int          DEB_T0_US        = 5000;
  localparam int          DEB_T1_US        = 15000;
  localparam int          DEB_T2_US        = 35000;
  localparam int          DEB_T3_US        = 50000;
  localparam int          DEB_C0           = DEB_T0_US * CLK_KHZ / 1000;
  localparam int          DEB_C1           = DEB_T1_US * CLK_KHZ / 1000;
  localparam int          DEB_C2           = DEB_T2_US * CLK_KHZ / 1000;
  localparam int          DEB_C3           = DEB_T3_US * CLK_KHZ / 1000;
endpackage : sgr_pkg

// *** verif/system_general_register_file_bench.sv ***
`timescale 1ns/1ns
module system_general_register_file_bench;
  localparam int DEB [4] = '{4, 6, 8, 10};
  logic        i_ref_clk        = 1'b0;
  logic        i_reset_n        = 1'b0;
  logic        i_wr             = 1'b0;
  logic        i_rd             = 1'b0;
  logic        i_headset_detect = 1'b0;
  logic        i_card_detect    = 1'b0;
  logic [11:0] i_addr           = 12'h000;
  logic [31:0] i_wdata          = 32'h00000000;
  logic [31:0] o_rdata, o_boot_rom_base;
  logic [7:0]  o_port3_group_a_pull_dis, o_port3_group_b_pull_dis, o_domain_idle_req;
  logic [7:0]  o_port3_group_c_pull_dis, o_port3_group_d_pull_dis;
  logic [3:0]  o_phy_lane_test_mode;
  logic [1:0]  o_spi_pin_select;
  logic        o_headset_irq, o_card_irq, o_remap, o_force_debug_mux, o_audio_src_codec;
  logic        o_codec_loopback, o_narrow_memory_enable, o_memory_width_sched, o_monitor_start;
  logic        o_monitor_lowpower_type, o_hdmi_clk_sel, o_phy_clk_test_mode, o_i2s_pin_select;
  logic        o_emmc_pin_select, o_vpu_clk_sel, o_codec_sel, o_gen3_memory_select;
  logic        o_usb_host_sel, o_phy_normal, o_self_refresh_req;
  int          n_errors     = 0;
  int          total_checks = 0;
  int          lat;

  sgr_regfile #(.DEB_CNT0(4), .DEB_CNT1(6), .DEB_CNT2(8), .DEB_CNT3(10)) dut (
    .i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_headset_detect, .i_card_detect, .o_headset_irq, .o_card_irq,
    .o_port3_group_a_pull_dis, .o_port3_group_b_pull_dis,
    .o_port3_group_c_pull_dis, .o_port3_group_d_pull_dis,
    .o_remap, .o_boot_rom_base, .o_force_debug_mux, .o_audio_src_codec, .o_codec_loopback,
    .o_narrow_memory_enable, .o_memory_width_sched, .o_monitor_start,
    .o_monitor_lowpower_type, .o_hdmi_clk_sel, .o_phy_lane_test_mode, .o_phy_clk_test_mode,
    .o_spi_pin_select, .o_i2s_pin_select, .o_emmc_pin_select, .o_vpu_clk_sel, .o_codec_sel,
    .o_domain_idle_req, .o_gen3_memory_select, .o_usb_host_sel, .o_phy_normal,
    .o_self_refresh_req
  );

  always #25 i_ref_clk = ~i_ref_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd

  // Drives a detect pin and counts cycles until the chosen interrupt rises.
  task automatic pin_irq(input bit card, input logic v, input int lo, input int hi);
    @(posedge i_ref_clk);
    if (card) i_card_detect <= v;
    else i_headset_detect <= v;
    for (lat = 1; lat <= 60; lat++) begin
      @(posedge i_ref_clk);
      #1;
      if ((card ? o_card_irq : o_headset_irq) === 1'b1) break;
    end
    if (lat > 60) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, lat, hi);
      give_verdict();
    end
    chk(32'(lat >= lo && lat <= hi), 32'h1);
  endtask : pin_irq

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rd(12'h130, 32'h0);
    rd(12'h13c, 32'h20);
    rd(12'h140, 32'h120);
    rd(12'h144, 32'h0);
    rd(12'h148, 32'h84);
    rd(12'h138, 32'h0);
    $display("reset values done");
    // Each debounce code in turn, edges alternating, pending cleared after each.
    for (int c = 0; c < 4; c++) begin
      wr(12'h140, 32'h003c0000 | 32'(c << 4) | 32'hc);
      pin_irq(1'b1, ~i_card_detect, DEB[c], DEB[c] + 6);
      rd(12'h140, 32'h10c | 32'(c << 4) | (i_card_detect ? 32'h1 : 32'h2));
      wr(12'h140, 32'h00030003);
      chk(o_card_irq, 1'b0);
    end
    $display("card detect done");
    pin_irq(1'b1, 1'b1, DEB[3], DEB[3] + 6);
    wr(12'h140, 32'h000c0000);
    chk(o_card_irq, 1'b0);
    rd(12'h140, 32'h131);
    repeat (30) @(posedge i_ref_clk);
    i_headset_detect <= 1'b1;
    repeat (30) @(posedge i_ref_clk);
    #1;
    chk(o_headset_irq, 1'b0);
    rd(12'h13c, 32'h21);
    wr(12'h13c, 32'h00040004);
    chk(o_headset_irq, 1'b1);
    wr(12'h13c, 32'h00010000);
    rd(12'h13c, 32'h25);
    wr(12'h13c, 32'h00010001);
    chk(o_headset_irq, 1'b0);
    wr(12'h13c, 32'h00380008);
    pin_irq(1'b0, 1'b0, DEB[0], DEB[0] + 6);
    rd(12'h13c, 32'h0e);
    wr(12'h13c, 32'h00020002);
    chk(o_headset_irq, 1'b0);
    $display("headset detect done");
    wr(12'h140, 32'hffffffff);
    rd(12'h140, 32'hfdfc);
    chk({o_remap, o_force_debug_mux, o_audio_src_codec, o_monitor_start}, 4'hf);
    chk({o_monitor_lowpower_type, o_narrow_memory_enable, o_memory_width_sched}, 3'h7);
    chk({o_codec_loopback, o_hdmi_clk_sel}, 2'h3);
    chk(o_narrow_memory_enable, 1'b1);
    chk(o_boot_rom_base, 32'h10100000);
    wr(12'h140, 32'h15400000);
    chk({o_remap, o_audio_src_codec, o_monitor_start, o_force_debug_mux}, 4'h0);
    chk(o_boot_rom_base, 32'h0);
    wr(12'h130, 32'h00ffa5a5);
    rd(12'h130, 32'h00a5);
    chk({o_port3_group_b_pull_dis, o_port3_group_a_pull_dis}, 16'h00a5);
    wr(12'h134, 32'hffff3c81);
    chk({o_port3_group_d_pull_dis, o_port3_group_c_pull_dis}, 16'h3c81);
    wr(12'h138, 32'hffffffff);
    rd(12'h138, 32'h0);
    $display("control 0 and pulls done");
    wr(12'h144, 32'hffff7890);
    chk({o_phy_lane_test_mode, o_phy_clk_test_mode, o_spi_pin_select}, 7'h7e);
    wr(12'h144, 32'h0000ffff);
    wr(12'h144, 32'h0307ffff);
    rd(12'h144, 32'h7890);
    chk({o_vpu_clk_sel, o_codec_sel, o_i2s_pin_select, o_emmc_pin_select}, 4'h0);
    wr(12'h148, 32'hffffff0c);
    rd(12'h148, 32'hff0c);
    chk({o_domain_idle_req, o_gen3_memory_select, o_phy_normal}, 10'h3fd);
    chk({o_usb_host_sel, o_self_refresh_req}, 2'h2);
    $display("control 1 and 2 done");
    give_verdict();
  end
endmodule : system_general_register_file_bench
